// ==== hdl/crr_readout.sv ====
// Notes on behaviour
// RQ1 - Three oversampling select inputs form a code, input 2 most significant.
// RQ2 - Bus line 15 carries bit 17 on first strobe, bit 1 on second.
// RQ3 - Bus line 14 carries bit 16 on first strobe, bit 0 on second.
// RQ4 - Lines 13..9 carry bits 15..11 first, zeros second.
// RQ5 - Line 8 carries bit 10 during first read in parallel mode.
// RQ6 - Line 7 carries bit 9 during first read in parallel mode.
// RQ7 - Lines 6..0 carry bits 8..2 first, zeros second.
// RQ8 - Parallel mode: bus driven only while chip select and read both low.
// RQ9 - Serial mode: lines 7 and 8 become serial outputs A and B.
// RQ10 - Serial mode: host ties unused parallel lines to ground.
// RQ11 - Results are two's complement, 0x1FFFF most positive, 0x20000 most negative.
// RQ12 - Host issues two read strobes per channel, upper sixteen bits first.
// RQ13 - Select low picks parallel, high picks serial with read as serial clock.
// RQ14 - After second strobe, next pair presents next channel, all eight in order.
`timescale 1ns/1ps
`default_nettype none
module crr_readout
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [crr_pkg::OVS_W-1:0] ovs_ratio_sel,
	input wire logic interface_select,
	input wire logic cs_n,
	input wire logic rd_sclk_n,
	input wire logic result_load,
	input wire logic [crr_pkg::NUM_CH*crr_pkg::RES_W-1:0] result_in,
	output logic [crr_pkg::OVS_W-1:0] ovs_code,
	output logic [crr_pkg::BUS_W-1:0] bus_out,
	output logic [crr_pkg::BUS_W-1:0] bus_oe,
	output logic [crr_pkg::CH_W-1:0] channel_index
);
	import crr_pkg::*;

	logic [RES_W-1:0] result_reg [NUM_CH];
	logic [CH_W-1:0] ch_reg;
	crr_phase_t phase_reg;
	logic rd_prev_reg;
	logic cs_prev_reg;
	logic [RES_W-1:0] shift_a_reg;
	logic [RES_W-1:0] shift_b_reg;
	logic [BUS_W-1:0] bus_reg;
	logic [OVS_W-1:0] ovs_reg;
	logic par_mode;
	logic rd_fall;
	logic rd_rise;
	logic cs_fall;
	logic [RES_W-1:0] cur;

	// Map one result onto the 16-bit bus for a given strobe phase
	function automatic logic [BUS_W-1:0] pack_bus(input logic [RES_W-1:0] r,
		input crr_phase_t ph);
		logic [BUS_W-1:0] v;
		v = '0;
		if (ph == CRR_PHASE_UPPER)
			v = r[FIRST_HI:FIRST_LO]; // RQ2 RQ3 RQ4 RQ5 RQ6 RQ7
		else
		begin
			v[SECOND_HI_POS] = r[SECOND_HI_SRC]; // RQ2
			v[SECOND_LO_POS] = r[SECOND_LO_SRC]; // RQ3
		end
		return v;
	endfunction : pack_bus

	assign par_mode = ~interface_select; // RQ13
	assign rd_fall = rd_prev_reg & ~rd_sclk_n;
	assign rd_rise = ~rd_prev_reg & rd_sclk_n;
	assign cs_fall = cs_prev_reg & ~cs_n;
	assign cur = result_reg[ch_reg];
	assign channel_index = ch_reg;
	assign ovs_code = ovs_reg;

	// Declared ahead of its use so strict front ends resolve it
	function automatic logic ovs_sel_msb(input logic [OVS_W-1:0] s);
		return s[OVS_W-1];
	endfunction : ovs_sel_msb

	always_ff @(posedge clk)
	begin
		if (reset)
			ovs_reg <= '0;
		else
			ovs_reg <= {ovs_sel_msb(ovs_ratio_sel), ovs_ratio_sel[1:0]}; // RQ1
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rd_prev_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
		end
		else
		begin
			rd_prev_reg <= rd_sclk_n;
			cs_prev_reg <= cs_n;
		end
	end

	// Results held as raw two's complement, no recoding
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < NUM_CH; i++)
				result_reg[i] <= RESULT_RESET;
		end
		else if (result_load)
		begin
			for (int i = 0; i < NUM_CH; i++)
				result_reg[i] <= result_in[i*RES_W +: RES_W]; // RQ11
		end
	end

	// Channel and phase sequencing
	always_ff @(posedge clk)
	begin
		if (reset || result_load)
		begin
			ch_reg <= CH_FIRST;
			phase_reg <= CRR_PHASE_UPPER;
		end
		else if (par_mode && !cs_n && rd_rise)
		begin
			if (phase_reg == CRR_PHASE_UPPER)
				phase_reg <= CRR_PHASE_LOWER; // RQ12
			else
			begin
				phase_reg <= CRR_PHASE_UPPER;
				ch_reg <= (ch_reg == CH_LAST) ? CH_FIRST : ch_reg + 3'h1; // RQ14
			end
		end
		else if (!par_mode && cs_fall)
			ch_reg <= CH_FIRST;
	end

	// Serial shifters: A shifts out only result_reg[0], B only result_reg[NUM_CH/2], MSB first, zero-filled
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			shift_a_reg <= '0;
			shift_b_reg <= '0;
		end
		else if (!par_mode && cs_fall)
		begin
			shift_a_reg <= result_reg[0];
			shift_b_reg <= result_reg[NUM_CH/2];
		end
		else if (!par_mode && !cs_n && rd_rise)
		begin
			shift_a_reg <= {shift_a_reg[RES_W-2:0], 1'b0};
			shift_b_reg <= {shift_b_reg[RES_W-2:0], 1'b0};
		end
	end

	// Registered data; captured on the read falling edge so it holds steady
	always_ff @(posedge clk)
	begin
		if (reset)
			bus_reg <= '0;
		else if (par_mode && rd_fall)
			bus_reg <= pack_bus(cur, phase_reg);
	end

	always_comb
	begin
		bus_out = '0;
		bus_oe = '0;
		if (par_mode)
		begin
			bus_out = bus_reg;
			if (!cs_n && !rd_sclk_n)
				bus_oe = '1; // RQ8
		end
		else
		begin
			// Other lines left undriven; board grounds them
			bus_out[SER_A_POS] = shift_a_reg[RES_W-1]; // RQ9
			bus_out[SER_B_POS] = shift_b_reg[RES_W-1]; // RQ9
			if (!cs_n)
			begin
				bus_oe[SER_A_POS] = 1'b1;
				bus_oe[SER_B_POS] = 1'b1;
			end
		end
	end

	property p_oe_par;
		@(posedge clk) disable iff (reset)
		par_mode && (cs_n || rd_sclk_n) |-> bus_oe == '0;
	endproperty
	a_oe_par: assert property (p_oe_par) else $error("bus driven outside read"); // RQ8

	property p_first_map;
		@(posedge clk) disable iff (reset)
		par_mode && rd_fall && phase_reg == CRR_PHASE_UPPER && !result_load
		|=> bus_out == $past(cur[FIRST_HI:FIRST_LO]);
	endproperty
	a_first_map: assert property (p_first_map) else $error("first read map wrong"); // RQ2

	property p_second_zero;
		@(posedge clk) disable iff (reset)
		par_mode && rd_fall && phase_reg == CRR_PHASE_LOWER
		|=> bus_out[13:0] == 14'h0000;
	endproperty
	a_second_zero: assert property (p_second_zero) else $error("second read not zero"); // RQ4

	property p_second_bits;
		@(posedge clk) disable iff (reset)
		par_mode && rd_fall && phase_reg == CRR_PHASE_LOWER && !result_load
		|=> bus_out[15:14] == $past(cur[1:0]);
	endproperty
	a_second_bits: assert property (p_second_bits) else $error("second read bits wrong"); // RQ3

	property p_advance;
		@(posedge clk) disable iff (reset)
		par_mode && !cs_n && rd_rise && phase_reg == CRR_PHASE_LOWER && !result_load
		|=> ch_reg == $past(ch_reg) + 3'h1;
	endproperty
	a_advance: assert property (p_advance) else $error("channel did not advance"); // RQ14

	property p_hold_phase;
		@(posedge clk) disable iff (reset)
		par_mode && !cs_n && rd_rise && phase_reg == CRR_PHASE_UPPER && !result_load
		|=> phase_reg == CRR_PHASE_LOWER && $stable(ch_reg);
	endproperty
	a_hold_phase: assert property (p_hold_phase) else $error("phase step wrong"); // RQ12

	property p_serial_pins;
		@(posedge clk) disable iff (reset)
		!par_mode |-> bus_oe[6:0] == 7'h00 && bus_oe[15:9] == 7'h00
			&& bus_oe[SER_A_POS] == !cs_n;
	endproperty
	a_serial_pins: assert property (p_serial_pins) else $error("serial pins wrong"); // RQ9

	property p_ovs;
		@(posedge clk) disable iff (reset)
		1'b1 |=> ovs_code == $past(ovs_ratio_sel);
	endproperty
	a_ovs: assert property (p_ovs) else $error("oversampling code wrong"); // RQ1

	property p_oe_read;
		@(posedge clk) disable iff (reset)
		par_mode && !cs_n && !rd_sclk_n |-> bus_oe == '1;
	endproperty
	a_oe_read: assert property (p_oe_read) else $error("bus not driven in read"); // RQ8

	// Host may sample late in the strobe; data must not drift meanwhile
	property p_bus_hold;
		@(posedge clk) disable iff (reset)
		par_mode && !rd_fall
		|=> !par_mode || $stable(bus_out);
	endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("bus data drifted"); // RQ2

	property p_no_cs_hold;
		@(posedge clk) disable iff (reset)
		par_mode && cs_n && !result_load
		|=> $stable(phase_reg) && $stable(ch_reg);
	endproperty
	a_no_cs_hold: assert property (p_no_cs_hold) else $error("step without select"); // RQ14

	property p_wrap;
		@(posedge clk) disable iff (reset)
		par_mode && !cs_n && rd_rise && phase_reg == CRR_PHASE_LOWER && ch_reg == CH_LAST
		&& !result_load |=> ch_reg == CH_FIRST;
	endproperty
	a_wrap: assert property (p_wrap) else $error("channel did not wrap"); // RQ14

	property p_load_restart;
		@(posedge clk) disable iff (reset)
		result_load
		|=> ch_reg == CH_FIRST && phase_reg == CRR_PHASE_UPPER;
	endproperty
	a_load_restart: assert property (p_load_restart) else $error("load did not restart"); // RQ14

	// Raw storage: any recoding would break the signed full-scale codes
	property p_result_raw;
		@(posedge clk) disable iff (reset)
		result_load
		|=> result_reg[0] == $past(result_in[RES_W-1:0]);
	endproperty
	a_result_raw: assert property (p_result_raw) else $error("result not stored raw"); // RQ11

	property p_ser_b;
		@(posedge clk) disable iff (reset)
		!par_mode |-> bus_oe[SER_B_POS] == !cs_n;
	endproperty
	a_ser_b: assert property (p_ser_b) else $error("serial B enable wrong"); // RQ9

	property p_ser_load;
		@(posedge clk) disable iff (reset)
		!par_mode && cs_fall
		|=> shift_a_reg == $past(result_reg[0]) && shift_b_reg == $past(result_reg[NUM_CH/2]);
	endproperty
	a_ser_load: assert property (p_ser_load) else $error("serial load wrong"); // RQ9

	property p_ser_shift;
		@(posedge clk) disable iff (reset)
		!par_mode && !cs_n && rd_rise && !cs_fall
		|=> shift_a_reg == {$past(shift_a_reg[RES_W-2:0]), 1'b0}
			&& shift_b_reg == {$past(shift_b_reg[RES_W-2:0]), 1'b0};
	endproperty
	a_ser_shift: assert property (p_ser_shift) else $error("serial shift wrong"); // RQ13

endmodule : crr_readout
`default_nettype wire

// ==== pkg/crr_pkg.sv ====
package crr_pkg;
	localparam int RES_W = 18;
	localparam int BUS_W = 16;
	localparam int NUM_CH = 8;
	localparam int CH_W = 3;
	localparam int OVS_W = 3;
	// Parallel bus field layout
	localparam int FIRST_HI = 17;
	localparam int FIRST_LO = 2;
	localparam int SECOND_HI_POS = 15;
	localparam int SECOND_LO_POS = 14;
	localparam int SECOND_HI_SRC = 1;
	localparam int SECOND_LO_SRC = 0;
	localparam int SER_A_POS = 7;
	localparam int SER_B_POS = 8;
	localparam logic [RES_W-1:0] CODE_POS_FS = 18'h1FFFF;
	localparam logic [RES_W-1:0] CODE_NEG_FS = 18'h20000;
	localparam logic [RES_W-1:0] RESULT_RESET = 18'h00000;
	localparam logic [CH_W-1:0] CH_FIRST = 3'h0;
	localparam logic [CH_W-1:0] CH_LAST = 3'h7;
	typedef enum logic {CRR_PHASE_UPPER, CRR_PHASE_LOWER} crr_phase_t;
endpackage : crr_pkg

// ==== test/crr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module crr_host_model
(
	input wire logic clk,
	input wire logic go,
	input wire logic frame,
	input wire logic ser,
	input wire logic [crr_pkg::BUS_W-1:0] bus_out,
	input wire logic [crr_pkg::BUS_W-1:0] bus_oe,
	output logic cs_n,
	output logic rd_sclk_n,
	output logic got,
	output logic [crr_pkg::BUS_W-1:0] data
);
	import crr_pkg::*;
	logic [BUS_W-1:0] line;
	// Floating lines show stale inverse in parallel mode so a missing enable is caught; in serial mode they read 0
	always_comb
		for (int i = 0; i < BUS_W; i++)
			line[i] = bus_oe[i] ? bus_out[i] : (ser ? 1'b0 : ~data[i]);
	initial
	begin
		cs_n = 1'b1;
		rd_sclk_n = 1'b1;
		got = 1'b0;
		data = '0;
	end
	always @(posedge clk)
	begin
		cs_n <= ~frame;
		got <= 1'b0;
		if (go === 1'b1)
		begin
			rd_sclk_n <= 1'b0;
			repeat (3) @(posedge clk);
			data <= line;
			got <= 1'b1;
			rd_sclk_n <= 1'b1;
		end
	end
endmodule : crr_host_model
`default_nettype wire

// ==== test/conversion_result_readout_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module conversion_result_readout_tb_top;
	import crr_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic go = 1'b0;
	logic frame = 1'b0;
	logic interface_select = 1'b0;
	logic result_load = 1'b0;
	logic [OVS_W-1:0] ovs_ratio_sel = '0;
	logic [NUM_CH*RES_W-1:0] result_in = '0;
	logic cs_n, rd_sclk_n, got;
	logic [BUS_W-1:0] bus_out, bus_oe, data;
	logic [OVS_W-1:0] ovs_code;
	logic [CH_W-1:0] ch_idx;
	logic [RES_W-1:0] r[NUM_CH];
	logic [BUS_W-1:0] q[$];
	int n_fail = 0;
	int n_checks = 0;
	int seed = 72426;
	int cyc = 0;
	always #50 clk = ~clk;
	crr_readout u_dut (.clk, .reset, .ovs_ratio_sel, .interface_select, .cs_n, .rd_sclk_n,
		.result_load, .result_in, .ovs_code, .bus_out, .bus_oe, .channel_index(ch_idx));
	crr_host_model u_host (.clk, .go, .frame, .ser(interface_select), .bus_out, .bus_oe,
		.cs_n, .rd_sclk_n, .got, .data);
	task test_done;
		if (n_fail == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task check(input string nm, input logic [BUS_W-1:0] s, input logic [BUS_W-1:0] e);
		n_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task strobe(input logic [BUS_W-1:0] e);
		q.push_back(e);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (int i = 0; i < 12 && got !== 1'b1; i++)
			@(posedge clk);
	endtask : strobe
	always @(posedge clk)
		if (got === 1'b1 && q.size() > 0)
			check("bus word", data, q.pop_front());
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			test_done();
		end
	end
	initial
	begin
		for (int i = 0; i < NUM_CH; i++)
			r[i] = RES_W'($random(seed));
		r[1] = CODE_POS_FS;
		r[2] = CODE_NEG_FS;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		ovs_ratio_sel <= 3'h6;
		for (int i = 0; i < NUM_CH; i++)
			result_in[i*RES_W +: RES_W] <= r[i];
		result_load <= 1'b1;
		@(posedge clk);
		result_load <= 1'b0;
		frame <= 1'b1;
		@(posedge clk);
		check("ovs code", {13'h0000, ovs_code}, 16'h0006);
		// One extra channel proves the wrap back to channel 0
		for (int k = 0; k <= NUM_CH; k++)
		begin
			strobe(r[k % NUM_CH][FIRST_HI:FIRST_LO]);
			check("channel", {13'h0000, ch_idx}, 16'(k % NUM_CH));
			strobe({r[k % NUM_CH][1:0], 14'h0000});
		end
		frame <= 1'b0;
		repeat (2) @(posedge clk);
		check("idle oe", bus_oe, 16'h0000);
		interface_select <= 1'b1;
		@(posedge clk);
		frame <= 1'b1;
		repeat (3) @(posedge clk);
		check("serial oe", bus_oe & 16'h0180, 16'h0180);
		check("serial bits", bus_out & 16'h0180, {7'h00, r[4][17], r[0][17], 7'h00});
		// Each serial clock rise must bring the next lower bit of both streams
		for (int j = RES_W - 1; j >= 0; j--)
			strobe({7'h00, r[4][j], r[0][j], 7'h00});
		@(posedge clk);
		check("queue left", 16'(q.size()), 16'h0000);
		test_done();
	end
endmodule : conversion_result_readout_tb_top
`default_nettype wire
